// ==== rtl/sac_pkg.sv ====
// shared constants and types for the converter sequencing and serial readout block
package sac_pkg;

  // ***********************************************************
  // data and counter widths
  // ***********************************************************
  localparam int DATA_W = 16;                 // conversion result width
  localparam int EDGE_W = 5;                  // serial clock falling edge counter width
  localparam int CONV_CNT_W = 8;              // conversion cycle counter width

  // ***********************************************************
  // frame lengths in serial clock falling edges, and result bit indices
  // ***********************************************************
  localparam logic [EDGE_W-1:0] FRAME_PLAIN = 5'h10;  // result bits only
  localparam logic [EDGE_W-1:0] FRAME_BUSY = 5'h11;   // indicator bit plus result bits
  localparam logic [EDGE_W-1:0] MSB_INDEX = 5'h0f;    // bit index of the result msb
  localparam logic [EDGE_W-1:0] BUSY_INDEX = 5'h10;   // index offset when indicator leads

  // ***********************************************************
  // timing: conversion window and system clock period
  // ***********************************************************
  localparam int SYS_CLK_NS = 50;             // 20 MHz system clock
  localparam int T_CONV_MIN_NS = 500;         // least conversion time
  localparam int T_CONV_MAX_NS = 1000;        // longest conversion time
  // least time rounds up, longest time rounds down
  localparam int CONV_MIN_CYC = (T_CONV_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int CONV_MAX_CYC = T_CONV_MAX_NS / SYS_CLK_NS;

  // ***********************************************************
  // reset values and busy indicator level
  // ***********************************************************
  localparam logic RST_LOW = 1'b0;            // flags and output drive after reset
  localparam logic BUSY_BIT = 1'b0;           // level of the busy indicator bit

  // sequencing states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_WAIT,
    ST_SHIFT
  } sac_state_t;

endpackage

// ==== rtl/sac_sync.sv ====
// two flip-flop synchroniser for a group of independent levels
`timescale 1ns/1ps

module sac_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // ***********************************************************
  // synchroniser stages
  // ***********************************************************
  logic [WIDTH-1:0] meta_ff;      // first stage, read only by the second stage
  logic [WIDTH-1:0] sync_ff;      // second stage, safe to use
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // next values: plain shift
  always_comb
  begin
    nxt_meta = i_async;
    nxt_sync = meta_ff;
  end

  // registers, synchronous reset to zero
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign o_sync = sync_ff;

endmodule

// ==== rtl/sac_core.sv ====
// conversion sequencing and chip-select-mode serial readout of a 16-bit converter
`timescale 1ns/1ps

module sac_core #(
  parameter int CONV_CYCLES = 15              // conversion length in internal clock cycles
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_sample_trigger,
  input wire logic i_select,
  input wire logic [sac_pkg::DATA_W-1:0] i_sample_code,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_core_active,
  output logic o_converting,
  output logic o_cs_mode
);

  // ***********************************************************
  // conversion length, clamped into the legal window
  // ***********************************************************
  localparam int CONV_EFF = (CONV_CYCLES < sac_pkg::CONV_MIN_CYC) ? sac_pkg::CONV_MIN_CYC :
    ((CONV_CYCLES > sac_pkg::CONV_MAX_CYC) ? sac_pkg::CONV_MAX_CYC : CONV_CYCLES);
  localparam logic [sac_pkg::CONV_CNT_W-1:0] CONV_LAST = sac_pkg::CONV_CNT_W'(CONV_EFF - 1);

  // ***********************************************************
  // link domain: serial clock falling edge counter
  // ***********************************************************
  // free-running gray count; cleared only through the link reset chain, never per frame, so the
  // system domain measures a frame as a difference from a snapshot
  logic [1:0] lrst_ff;                        // reset brought into the link domain
  logic [1:0] nxt_lrst;
  logic [sac_pkg::EDGE_W-1:0] lbin_ff;        // binary edge count
  logic [sac_pkg::EDGE_W-1:0] lgray_ff;       // gray copy, the only word that crosses
  logic [sac_pkg::EDGE_W-1:0] nxt_lbin;
  logic [sac_pkg::EDGE_W-1:0] nxt_lgray;

  // next values of the link counter
  always_comb
  begin
    nxt_lrst = {lrst_ff[0], 1'b0};
    nxt_lbin = lbin_ff + 5'h01;
    nxt_lgray = nxt_lbin ^ (nxt_lbin >> 1);
    if (lrst_ff[1])
    begin
      nxt_lbin = '0;
      nxt_lgray = '0;
    end
  end

  // link registers; reset is caught asynchronously into the chain as a constant only
  always_ff @(negedge i_sclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      lrst_ff <= 2'h3;
    end
    else
    begin
      lrst_ff <= nxt_lrst;
    end
  end

  // counter registers, one step per serial clock falling edge
  always_ff @(negedge i_sclk)
  begin
    lbin_ff <= nxt_lbin;
    lgray_ff <= nxt_lgray;
  end

  // ***********************************************************
  // pin and count synchronisers into the system domain
  // ***********************************************************
  logic [sac_pkg::EDGE_W+1:0] sync_out;       // {gray count, select, trigger}
  logic trig_s;                               // synchronised trigger level
  logic sel_s;                                // synchronised select level
  logic [sac_pkg::EDGE_W-1:0] gray_s;         // synchronised gray edge count

  sac_sync #(
    .WIDTH(sac_pkg::EDGE_W + 2)
  ) u_sync (
    .i_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_async({lgray_ff, i_select, i_sample_trigger}),
    .o_sync(sync_out)
  );

  assign trig_s = sync_out[0];
  assign sel_s = sync_out[1];
  assign gray_s = sync_out[sac_pkg::EDGE_W+1:2];

  // ***********************************************************
  // system domain: sequencing state
  // ***********************************************************
  sac_pkg::sac_state_t state_ff;              // sequencing state
  sac_pkg::sac_state_t nxt_state;
  logic trig_d_ff;                            // previous trigger level, for edges
  logic sel_d_ff;                             // previous select level, for edges
  logic [sac_pkg::CONV_CNT_W-1:0] conv_cnt_ff; // cycles spent converting
  logic [sac_pkg::DATA_W-1:0] result_ff;      // held conversion result
  logic [sac_pkg::EDGE_W-1:0] base_ff;        // edge count snapshot at frame start
  logic busy_ff;                              // frame opens with the busy bit
  logic cs_is_sel_ff;                         // select, not trigger, frames the read
  logic cs_mode_ff;                           // mode caught at trigger rise
  logic dout_ff;                              // serial output data
  logic oe_ff;                                // serial output drive enable
  logic core_ff;                              // converter core powered
  logic conv_ff;                              // conversion running, drives o_converting
  logic [sac_pkg::CONV_CNT_W-1:0] nxt_conv_cnt;
  logic [sac_pkg::DATA_W-1:0] nxt_result;
  logic [sac_pkg::EDGE_W-1:0] nxt_base;
  logic nxt_busy;
  logic nxt_cs_is_sel;
  logic nxt_cs_mode;
  logic nxt_dout;
  logic nxt_oe;
  logic nxt_core;
  logic nxt_conv;

  // edge and frame helpers
  logic trig_rise;
  logic trig_fall;
  logic sel_rise;
  logic sel_fall;
  logic [sac_pkg::EDGE_W-1:0] edges_bin;      // synchronised count, back to binary
  logic [sac_pkg::EDGE_W-1:0] edge_n;         // falls seen since the frame opened
  logic [sac_pkg::EDGE_W-1:0] bit_idx;        // result bit shown for edge_n
  logic [sac_pkg::EDGE_W-1:0] frame_len;      // falls that end this frame

  // gray to binary, msb copied, one generate stage per lower bit
  assign edges_bin[sac_pkg::EDGE_W-1] = gray_s[sac_pkg::EDGE_W-1];
  genvar gi;
  generate
    for (gi = 0; gi < sac_pkg::EDGE_W - 1; gi = gi + 1)
    begin : g_gray
      assign edges_bin[gi] = edges_bin[gi+1] ^ gray_s[gi];
    end
  endgenerate

  // edges and frame position
  always_comb
  begin
    trig_rise = trig_s & ~trig_d_ff;
    trig_fall = ~trig_s & trig_d_ff;
    sel_rise = sel_s & ~sel_d_ff;
    sel_fall = ~sel_s & sel_d_ff;
    edge_n = edges_bin - base_ff;
    // busy frame: bit 0 is the indicator, result msb on the first fall
    if (busy_ff)
    begin
      frame_len = sac_pkg::FRAME_BUSY;
      bit_idx = sac_pkg::BUSY_INDEX - edge_n;
    end
    else
    begin
      frame_len = sac_pkg::FRAME_PLAIN;
      bit_idx = sac_pkg::MSB_INDEX - edge_n;
    end
  end

  // next values of the sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_conv_cnt = conv_cnt_ff;
    nxt_result = result_ff;
    nxt_base = base_ff;
    nxt_busy = busy_ff;
    nxt_cs_is_sel = cs_is_sel_ff;
    nxt_cs_mode = cs_mode_ff;
    nxt_dout = dout_ff;
    nxt_oe = oe_ff;
    nxt_core = core_ff;
    if (trig_rise && state_ff != sac_pkg::ST_CONV)
    begin
      // new sample: mode from select, output released, core wakes
      nxt_cs_mode = sel_s;
      nxt_oe = 1'b0;
      nxt_result = i_sample_code;
      nxt_core = 1'b1;
      nxt_conv_cnt = '0;
      nxt_state = sac_pkg::ST_CONV;
    end
    else
    begin
      case (state_ff)
        sac_pkg::ST_CONV:
        begin
          // trigger is ignored until the count runs out
          nxt_conv_cnt = conv_cnt_ff + 8'h01;
          if (conv_cnt_ff == CONV_LAST)
          begin
            nxt_core = 1'b0;
            nxt_base = edges_bin;
            nxt_dout = sac_pkg::BUSY_BIT;
            if (!cs_mode_ff)
            begin
              // chained mode is not served here: output stays released
              nxt_state = sac_pkg::ST_IDLE;
            end
            else if (!trig_s || !sel_s)
            begin
              // a low line at completion asks for the busy bit
              nxt_busy = 1'b1;
              nxt_cs_is_sel = trig_s;
              nxt_oe = 1'b1;
              nxt_state = sac_pkg::ST_SHIFT;
            end
            else
            begin
              nxt_busy = 1'b0;
              nxt_state = sac_pkg::ST_WAIT;
            end
          end
        end
        sac_pkg::ST_WAIT:
        begin
          // acquisition: a chip-select fall opens the plain frame with the msb
          if ((trig_fall && sel_s) || (sel_fall && trig_s))
          begin
            nxt_cs_is_sel = sel_fall;
            nxt_base = edges_bin;
            nxt_dout = result_ff[sac_pkg::DATA_W-1];
            nxt_oe = 1'b1;
            nxt_state = sac_pkg::ST_SHIFT;
          end
        end
        sac_pkg::ST_SHIFT:
        begin
          if (cs_is_sel_ff && sel_rise)
          begin
            nxt_oe = 1'b0;
            nxt_state = sac_pkg::ST_IDLE;
          end
          else if (edge_n >= frame_len)
          begin
            nxt_oe = 1'b0;
            nxt_state = sac_pkg::ST_IDLE;
          end
          else if (busy_ff && edge_n == '0)
          begin
            nxt_dout = sac_pkg::BUSY_BIT;
          end
          else
          begin
            // bit stays until the next counted fall, valid on both edges
            nxt_dout = result_ff[bit_idx[3:0]];
          end
        end
        default:
        begin
          nxt_state = state_ff;
        end
      endcase
    end
    // registered copy of the state decode, so the output leaves a flip-flop
    nxt_conv = (nxt_state == sac_pkg::ST_CONV) ? 1'b1 : 1'b0;
  end

  // sequencer registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      state_ff <= sac_pkg::ST_IDLE;
      trig_d_ff <= sac_pkg::RST_LOW;
      sel_d_ff <= sac_pkg::RST_LOW;
      conv_cnt_ff <= '0;
      result_ff <= '0;
      base_ff <= '0;
      busy_ff <= sac_pkg::RST_LOW;
      cs_is_sel_ff <= sac_pkg::RST_LOW;
      cs_mode_ff <= sac_pkg::RST_LOW;
      dout_ff <= sac_pkg::RST_LOW;
      oe_ff <= sac_pkg::RST_LOW;
      core_ff <= sac_pkg::RST_LOW;
      conv_ff <= sac_pkg::RST_LOW;
    end
    else
    begin
      state_ff <= nxt_state;
      trig_d_ff <= trig_s;
      sel_d_ff <= sel_s;
      conv_cnt_ff <= nxt_conv_cnt;
      result_ff <= nxt_result;
      base_ff <= nxt_base;
      busy_ff <= nxt_busy;
      cs_is_sel_ff <= nxt_cs_is_sel;
      cs_mode_ff <= nxt_cs_mode;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
      core_ff <= nxt_core;
      conv_ff <= nxt_conv;
    end
  end

  // ***********************************************************
  // outputs, all straight from flip-flops
  // ***********************************************************
  // limitation: bits follow the serial clock through a synchroniser, so the
  // host must leave several system cycles between serial clock falls
  assign o_dout = dout_ff;
  assign o_dout_oe = oe_ff;
  assign o_core_active = core_ff;
  assign o_converting = conv_ff;
  assign o_cs_mode = cs_mode_ff;

endmodule

// ==== bench/sac_core_asserts.sv ====
// checker of the conversion sequencing and readout ports
`timescale 1ns/1ps

module sac_core_asserts #(
  parameter int CONV_CYCLES = 15
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_sample_trigger,
  input wire logic i_select,
  input wire logic [sac_pkg::DATA_W-1:0] i_sample_code,
  input wire logic o_dout,
  input wire logic o_dout_oe,
  input wire logic o_core_active,
  input wire logic o_converting,
  input wire logic o_cs_mode
);
  // ********
  // conversion length window, clamped as in the design
  // ********
  localparam int CONV_EFF = (CONV_CYCLES < sac_pkg::CONV_MIN_CYC) ? sac_pkg::CONV_MIN_CYC :
    (CONV_CYCLES > sac_pkg::CONV_MAX_CYC) ? sac_pkg::CONV_MAX_CYC : CONV_CYCLES;
  localparam int CONV_LO = CONV_EFF - 1; // one cycle slack for the state decode
  localparam int CONV_HI = CONV_EFF + 1;
  logic [7:0] conv_cnt_ff; // cycles seen converting
  logic [7:0] nxt_conv_cnt;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  // count while converting, clear otherwise
  always_comb
  begin
    nxt_conv_cnt = o_converting ? conv_cnt_ff + 8'h01 : 8'h00;
  end
  always_ff @(posedge i_sys_clk)
  begin
    conv_cnt_ff <= i_reset ? 8'h00 : nxt_conv_cnt;
  end
  // ********
  // properties
  // ********
  sequence s_trig_rise;
    $rose(i_sample_trigger) && !o_converting;
  endsequence
  sequence s_busy_start;
    $fell(o_converting) && o_dout_oe;
  endsequence
  chk_conv_length: assert property ($fell(o_converting) |->
    (conv_cnt_ff >= CONV_LO) && (conv_cnt_ff <= CONV_HI)) else $error("conversion length off");
  chk_trig_starts: assert property (s_trig_rise |-> ##[2:5] o_converting)
    else $error("trigger rise did not start a conversion");
  chk_mode_high: assert property ($rose(o_converting) && $past(i_select, 6) &&
    $past(i_select, 2) |-> ##[0:1] o_cs_mode) else $error("select high but chained mode");
  chk_oe_quiet: assert property (o_converting && $past(o_converting) |-> !o_dout_oe)
    else $error("output driven during conversion");
  chk_core_power: assert property (o_core_active |-> o_converting || $past(o_converting))
    else $error("core powered outside conversion");
  chk_busy_low: assert property (s_busy_start |-> !o_dout)
    else $error("busy indicator not low");
  chk_trig_off: assert property ($rose(i_sample_trigger) |-> ##[2:6] !o_dout_oe)
    else $error("trigger rise left output driven");
  chk_sel_off: assert property ($rose(i_select) && i_sample_trigger && o_dout_oe |->
    ##[2:6] !o_dout_oe) else $error("select rise left output driven");
  chk_chain_quiet: assert property (!o_cs_mode && !$past(o_cs_mode) &&
    !$past(o_cs_mode, 2) |-> !o_dout_oe) else $error("output driven in chained mode");
endmodule

bind sac_core sac_core_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_sclk(i_sclk),
  .i_sample_trigger(i_sample_trigger), .i_select(i_select), .i_sample_code(i_sample_code),
  .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_core_active(o_core_active),
  .o_converting(o_converting), .o_cs_mode(o_cs_mode));

// ==== bench/sac_host_model.sv ====
// behavioural host that starts conversions and clocks results out
`timescale 1ns/1ps

module sac_host_model (
  input wire logic i_line,
  output logic o_sample_trigger,
  output logic o_select,
  output logic o_sclk
);
  logic [16:0] data; // captured bits, newest in bit 0
  // idle levels: serial clock stands low outside frames
  initial
  begin
    o_sample_trigger = 1'b0;
    o_select = 1'b1;
    o_sclk = 1'b0;
    data = 17'h00000;
  end
  // start a conversion; sel is the select level seen at the trigger rise
  task automatic start(input bit four, input bit busy, input bit sel);
    o_select = 1'b1;
    #60 o_sample_trigger = 1'b0;
    #200 o_select = sel;
    #200 o_sample_trigger = 1'b1;
    #150 o_sample_trigger = four || !busy;
    #1300;
  endtask
  // chip-select fall for plain frames; busy frames are already driven
  task automatic select_dev(input bit four, input bit busy);
    if (!busy && four) o_select = 1'b0;
    if (!busy && !four) o_sample_trigger = 1'b0;
    #500;
  endtask
  // n clock pulses; the line is taken on each rising edge, mid-bit
  task automatic read(input int n, input int hp);
    repeat (n)
    begin
      o_sclk = 1'b1;
      data = {data[15:0], i_line};
      #(hp);
      o_sclk = 1'b0;
      #(hp);
    end
  endtask
  // deselect after a 300 ns pause, only when four is set; full frames have released the output by then, partial frames by the deselect or the next trigger rise
  task automatic stop(input bit four);
    #300;
    if (four) o_select = 1'b1;
    #300;
  endtask
endmodule

// ==== bench/tb_sac_core.sv ====
// self-checking bench for the converter sequencing and serial readout
`timescale 1ns/1ps

`define CHK(name, exp, got) \
  n_compared++; \
  if ((got) !== (exp)) \
  begin \
    fails++; \
    $display("ERROR %s expected %h seen %h", name, exp, got); \
  end

module tb_sac_core;
  logic i_sys_clk;
  logic i_reset;
  logic [sac_pkg::DATA_W-1:0] i_sample_code;
  logic o_dout, o_dout_oe, o_core_active, o_converting, o_cs_mode;
  wire trig, sel, sclk;
  wire line = o_dout_oe ? o_dout : 1'b1; // pull-up holds the line high when released
  int fails = 0;
  int n_compared = 0;
  int cyc = 0; // timeout counter
  logic [31:0] seed = 32'h00006c31;

  // ********
  // design, far-side host and clock
  // ********
  sac_core #(.CONV_CYCLES(15)) u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_sclk(sclk), .i_sample_trigger(trig), .i_select(sel), .i_sample_code(i_sample_code),
    .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_core_active(o_core_active),
    .o_converting(o_converting), .o_cs_mode(o_cs_mode));
  sac_host_model u_host (.i_line(line), .o_sample_trigger(trig), .o_select(sel), .o_sclk(sclk));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // ********
  // helpers
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h000000c5 : 32'h00000000);
  endfunction
  // a driven frame is the low indicator plus the code; a released line reads ones
  function automatic logic [16:0] exp_bits(input logic [15:0] c, input bit driven);
    return driven ? {sac_pkg::BUSY_BIT, c} : 17'h0ffff;
  endfunction
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one conversion and readout; partial frames use the fast link clock
  task automatic frame(input bit four, input bit busy, input bit full, input logic [15:0] c);
    @(posedge i_sys_clk);
    i_sample_code <= c;
    u_host.start(four, busy, 1'b1);
    `CHK("mode", 1'b1, o_cs_mode)
    `CHK("core idle", 1'b0, o_core_active)
    u_host.select_dev(four, busy);
    if (full)
    begin
      u_host.read(busy ? 16 : 15, 300);
      `CHK("oe held", 1'b1, o_dout_oe)
      u_host.read(1, 300);
      repeat (10) @(posedge i_sys_clk);
      #1;
      `CHK("oe off", 1'b0, o_dout_oe)
      `CHK("bits", exp_bits(c, 1'b1), busy ? u_host.data : {1'b0, u_host.data[15:0]})
    end
    else
      u_host.read(5, 6);
    u_host.stop(four);
  endtask

  // ********
  // hang guard and main sequence
  // ********
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    i_reset = 1'b1;
    i_sample_code = 16'h0000;
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    // the link reset chain only lets go on serial clock falls after release
    u_host.read(4, 6);
    repeat (5) @(posedge i_sys_clk);
    for (int i = 0; i < 9; i++)
    begin
      seed = lfsr(seed);
      frame(i % 3 == 2, i % 3 == 1, i < 6, i == 0 ? 16'h8000 : i == 1 ? 16'h7fff : seed[15:0]);
    end
    u_host.start(1'b0, 1'b0, 1'b0);
    `CHK("mode", 1'b0, o_cs_mode)
    u_host.select_dev(1'b0, 1'b0);
    u_host.read(16, 300);
    `CHK("released", exp_bits(16'h0000, 1'b0), {1'b0, u_host.data[15:0]})
    end_of_test();
  end
endmodule
